/* logic/rid_top.v */
// rotate instruction datapath: issues a rotate over four phases,
// reads and writes the file register port, holds working register,
// bank selector and flags behind an Avalon-MM slave.
// assumes the register file answers reads combinationally, same clock.
//
// Contract
// - rotate left shifts operand by one
// - rotate right through carry, lsb to carry
// - dest zero writes working register only
// - dest one writes back to file register
// - access zero: access bank; one: bank selector
// - extended set: indexed offset when access zero and f<=5Fh
// - one word, four phases: decode/read/process/write
`timescale 1ns/1ns
`default_nettype none
`include "rid_consts.vh"

module rid_top
(
   // clock and reset
   input  wire        clock,
   input  wire        nrst,
   // avalon-mm register slave
   input  wire [7:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [3:0]  byteenable,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output wire        waitrequest,
   // data memory file register port
   output reg  [11:0] fileAddr,
   output reg         fileRdEn,
   input  wire [7:0]  fileRdData,
   output reg         fileWrEn,
   output reg  [7:0]  fileWrData,
   // completion
   output reg         instrDone
);

   // ********************************************************************
   // phase states
   // ********************************************************************
   localparam [2:0] ST_IDLE = 3'b000;
   localparam [2:0] ST_Q1   = 3'b001;
   localparam [2:0] ST_Q2   = 3'b010;
   localparam [2:0] ST_Q3   = 3'b011;
   localparam [2:0] ST_Q4   = 3'b100;

   // ********************************************************************
   // state and software-visible registers
   // ********************************************************************
   reg  [2:0]  state_reg;      // current phase
   reg         ext_reg;        // extended instruction set enable
   reg  [3:0]  bank_reg;       // bank_selector
   reg  [7:0]  work_reg;       // working register
   reg         carry_reg;      // carry flag
   reg         zero_reg;       // zero flag
   reg         neg_reg;        // negative flag
   reg  [10:0] cmd_reg;        // latched rotate command
   reg  [11:0] index_reg;      // index base for literal offset mode
   reg  [7:0]  operand_reg;    // operand read in phase two
   reg  [7:0]  result_reg;     // result made in phase three
   reg         carryNew_reg;   // carry from phase three
   reg         zeroNew_reg;    // zero from phase three
   reg         negNew_reg;     // negative from phase three
   reg         rdAck_reg;      // read answer cycle
   wire        busy;           // instruction in flight
   wire        wrGo;           // write accepted this edge
   wire [7:0]  rotResult;      // rotator output
   wire        rotCarry;       // rotator carry
   wire        rotZero;        // rotator zero
   wire        rotNeg;         // rotator negative
   reg  [11:0] resolvedAddr;   // operand address from command

   assign busy = (state_reg != ST_IDLE);

   // ********************************************************************
   // bus handshake
   // ********************************************************************
   // reads take one wait cycle so read data come from a flip-flop;
   // writes stall while busy so software never races the phase four write
   assign waitrequest = (read & ~rdAck_reg) | (write & busy);
   assign wrGo        = write & ~busy;

   // ********************************************************************
   // operand address resolution
   // ********************************************************************
   // picks the 12-bit file address from f, access bit and mode
   always @*
   begin
      resolvedAddr = {bank_reg, cmd_reg[7:0]};
      if (!cmd_reg[`RID_CMD_ACCESS] && ext_reg && (cmd_reg[7:0] <= `RID_IDX_LIMIT))
      begin
         resolvedAddr = index_reg + {4'h0, cmd_reg[7:0]};
      end
      else if (!cmd_reg[`RID_CMD_ACCESS])
      begin
         if (cmd_reg[7:0] < `RID_ACC_SPLIT)
         begin
            resolvedAddr = {`RID_ACC_LOBANK, cmd_reg[7:0]};
         end
         else
         begin
            resolvedAddr = {`RID_ACC_HIBANK, cmd_reg[7:0]};
         end
      end
      else
      begin
         resolvedAddr = {bank_reg, cmd_reg[7:0]};
      end
   end

   // ********************************************************************
   // rotator
   // ********************************************************************
   rid_rotate_unit u_rotate
   (
      .opSel    (cmd_reg[`RID_CMD_OP]),
      .operand  (operand_reg),
      .carryIn  (carry_reg),
      .result   (rotResult),
      .carryOut (rotCarry),
      .zeroFlag (rotZero),
      .negFlag  (rotNeg)
   );

   // ********************************************************************
   // phase sequencer and datapath
   // ********************************************************************
   // one instruction: Q1 decode, Q2 read, Q3 process, Q4 write
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         state_reg    <= ST_IDLE;
         fileAddr     <= 12'h000;
         fileRdEn     <= 1'b0;
         fileWrEn     <= 1'b0;
         fileWrData   <= `RID_RST_BYTE;
         operand_reg  <= `RID_RST_BYTE;
         result_reg   <= `RID_RST_BYTE;
         carryNew_reg <= 1'b0;
         zeroNew_reg  <= 1'b0;
         negNew_reg   <= 1'b0;
         instrDone    <= 1'b0;
      end
      else
      begin
         instrDone <= 1'b0;
         case (state_reg)
            // wait for a command write
            ST_IDLE:
            begin
               if (wrGo && (address == `RID_OFS_CMD) && byteenable[0])
               begin
                  state_reg <= ST_Q1;
               end
            end
            ST_Q1:
            begin
               fileAddr  <= resolvedAddr;
               fileRdEn  <= 1'b1;
               state_reg <= ST_Q2;
            end
            ST_Q2:
            begin
               operand_reg <= fileRdData;
               fileRdEn    <= 1'b0;
               state_reg   <= ST_Q3;
            end
            ST_Q3:
            begin
               result_reg   <= rotResult;
               carryNew_reg <= rotCarry;
               zeroNew_reg  <= rotZero;
               negNew_reg   <= rotNeg;
               fileWrData   <= rotResult;
               fileWrEn     <= cmd_reg[`RID_CMD_DEST];
               state_reg    <= ST_Q4;
            end
            ST_Q4:
            begin
               fileWrEn  <= 1'b0;
               instrDone <= 1'b1;
               state_reg <= ST_IDLE;
            end
            // unused codes fall back to idle
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ********************************************************************
   // software registers and flag commit
   // ********************************************************************
   // bus writes only land while idle, so they never meet the Q4 commit
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         ext_reg   <= 1'b0;
         bank_reg  <= `RID_RST_BANK;
         work_reg  <= `RID_RST_BYTE;
         carry_reg <= 1'b0;
         zero_reg  <= 1'b0;
         neg_reg   <= 1'b0;
         cmd_reg   <= `RID_RST_CMD;
         index_reg <= `RID_RST_INDEX;
      end
      else if (state_reg == ST_Q4)
      begin
         if (!cmd_reg[`RID_CMD_DEST])
         begin
            work_reg <= result_reg;
         end
         carry_reg <= carryNew_reg;
         zero_reg  <= zeroNew_reg;
         neg_reg   <= negNew_reg;
      end
      else if (wrGo)
      begin
         // decode the write target
         if (address == `RID_OFS_CTRL)
         begin
            if (byteenable[0]) ext_reg <= writedata[`RID_CTRL_EXT];
         end
         else if (address == `RID_OFS_BANK)
         begin
            if (byteenable[0]) bank_reg <= writedata[3:0];
         end
         else if (address == `RID_OFS_WORK)
         begin
            if (byteenable[0]) work_reg <= writedata[7:0];
         end
         else if (address == `RID_OFS_STATUS)
         begin
            if (byteenable[0])
            begin
               carry_reg <= writedata[`RID_ST_CARRY];
               zero_reg  <= writedata[`RID_ST_ZERO];
               neg_reg   <= writedata[`RID_ST_NEG];
            end
         end
         else if (address == `RID_OFS_CMD)
         begin
            // command needs the low byte; the high byte alone is ignored
            if (byteenable[0])
            begin
               cmd_reg[7:0] <= writedata[7:0];
               if (byteenable[1]) cmd_reg[10:8] <= writedata[10:8];
            end
         end
         else if (address == `RID_OFS_INDEX)
         begin
            if (byteenable[0]) index_reg[7:0]  <= writedata[7:0];
            if (byteenable[1]) index_reg[11:8] <= writedata[11:8];
         end
      end
   end

   // ********************************************************************
   // read answer
   // ********************************************************************
   // first read cycle loads data, second drops waitrequest
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         rdAck_reg <= 1'b0;
         readdata  <= 32'h0000_0000;
      end
      else
      begin
         rdAck_reg <= read & ~rdAck_reg;
         if (read && !rdAck_reg)
         begin
            // unmapped offsets read zero
            if (address == `RID_OFS_CTRL)
               readdata <= {31'h0000_0000, ext_reg};
            else if (address == `RID_OFS_BANK)
               readdata <= {28'h000_0000, bank_reg};
            else if (address == `RID_OFS_WORK)
               readdata <= {24'h00_0000, work_reg};
            else if (address == `RID_OFS_STATUS)
               readdata <= {24'h00_0000, busy, 4'h0, neg_reg, zero_reg, carry_reg};
            else if (address == `RID_OFS_CMD)
               readdata <= {21'h00_0000, cmd_reg};
            else if (address == `RID_OFS_INDEX)
               readdata <= {20'h0_0000, index_reg};
            else
               readdata <= 32'h0000_0000;
         end
      end
   end

endmodule // rid_top
`default_nettype wire

/* logic/rid_consts.vh */
// constants for the rotate instruction datapath: register offsets,
// field positions, reset values and the phase count.
// assumes byte addressing on a 32-bit Avalon-MM register port.
`ifndef RID_CONSTS_VH
`define RID_CONSTS_VH

// ********************************************************************
// register byte offsets
// ********************************************************************
`define RID_OFS_CTRL     8'h00
`define RID_OFS_BANK     8'h04
`define RID_OFS_WORK     8'h08
`define RID_OFS_STATUS   8'h0C
`define RID_OFS_CMD      8'h10
`define RID_OFS_INDEX    8'h14

// ********************************************************************
// field positions
// ********************************************************************
`define RID_CTRL_EXT     0
`define RID_ST_CARRY     0
`define RID_ST_ZERO      1
`define RID_ST_NEG       2
`define RID_ST_BUSY      7
`define RID_CMD_DEST     8
`define RID_CMD_ACCESS   9
`define RID_CMD_OP       10

// ********************************************************************
// operation codes and address constants
// ********************************************************************
`define RID_OP_ROTL      1'b0
`define RID_OP_ROTR      1'b1
`define RID_IDX_LIMIT    8'h5F
`define RID_ACC_SPLIT    8'h60
`define RID_ACC_HIBANK   4'hF
`define RID_ACC_LOBANK   4'h0

// ********************************************************************
// reset values
// ********************************************************************
`define RID_RST_BYTE     8'h00
`define RID_RST_BANK     4'h0
`define RID_RST_INDEX    12'h000
`define RID_RST_CMD      11'h300
`define RID_QPHASES      4

`endif

/* logic/rid_rotate_unit.v */
// combinational rotator for the two rotate instructions, with flags.
// assumes the caller registers its inputs and outputs.
`timescale 1ns/1ns
`default_nettype none
`include "rid_consts.vh"

module rid_rotate_unit
(
   // operation select and operand
   input  wire       opSel,
   input  wire [7:0] operand,
   input  wire       carryIn,
   // result and flags
   output reg  [7:0] result,
   output reg        carryOut,
   output wire       zeroFlag,
   output wire       negFlag
);

   // ********************************************************************
   // rotate datapath
   // ********************************************************************
   // select one of the two rotations; carry is untouched by the left one
   always @*
   begin
      if (opSel == `RID_OP_ROTR)
      begin
         result   = {carryIn, operand[7:1]};
         carryOut = operand[0];
      end
      else
      begin
         result   = {operand[6:0], operand[7]};
         carryOut = carryIn;
      end
   end

   assign zeroFlag = (result == 8'h00);
   assign negFlag  = result[7];

endmodule // rid_rotate_unit
`default_nettype wire

/* bench/rid_chk_sva.sv */
// checker for the rotate datapath: phase timing, results, addressing.
// assumes it is bound to rid_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "rid_consts.vh"
module rid_chk
(
   // clock and reset
   input wire logic        clock,
   input wire logic        nrst,
   // register bus
   input wire logic [7:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // file register port
   input wire logic [11:0] fileAddr,
   input wire logic        fileRdEn,
   input wire logic [7:0]  fileRdData,
   input wire logic        fileWrEn,
   input wire logic [7:0]  fileWrData,
   input wire logic        instrDone
);
   // ******************************************************************
   // shadow of the accepted command and bank selector
   // ******************************************************************
   logic        cmdGo;   // command write taken this edge
   logic        bankGo;  // bank write taken this edge
   logic [10:0] cmdReg;  // last accepted command
   logic [3:0]  bankReg; // last accepted bank selector
   assign cmdGo = write && !waitrequest && byteenable[0] && address == `RID_OFS_CMD;
   assign bankGo = write && !waitrequest && byteenable[0] && address == `RID_OFS_BANK;
   // new commands stall while busy, so the shadow holds through q4
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         cmdReg <= `RID_RST_CMD;
         bankReg <= `RID_RST_BANK;
      end
      else
      begin
         // the upper command bits need both lane zero and lane one, as in the design
         if (cmdGo) cmdReg[7:0] <= writedata[7:0];
         if (cmdGo && byteenable[1]) cmdReg[10:8] <= writedata[10:8];
         if (bankGo) bankReg <= writedata[3:0];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // ******************************************************************
   // assertions
   // ******************************************************************
   chk_q2_read: assert property (cmdGo |-> ##2 fileRdEn ##1 !fileRdEn)
      else $error("file read not a single pulse in phase two");
   chk_done_pulse: assert property (fileRdEn |-> ##3 instrDone ##1 !instrDone)
      else $error("completion pulse misplaced");
   chk_dest_write: assert property (fileRdEn |-> ##2 fileWrEn == cmdReg[8])
      else $error("file write does not follow destination bit");
   chk_wr_slot: assert property (fileWrEn |-> $past(fileRdEn, 2))
      else $error("file write outside phase four");
   chk_rotl_res: assert property (fileWrEn && !cmdReg[10] |->
      fileWrData == {$past(fileRdData[6:0], 2), $past(fileRdData[7], 2)})
      else $error("left rotate result wrong");
   chk_rotr_res: assert property (fileWrEn && cmdReg[10] |->
      fileWrData[6:0] == $past(fileRdData[7:1], 2))
      else $error("right rotate result wrong");
   chk_bank_addr: assert property (fileRdEn && cmdReg[9] |->
      fileAddr == {bankReg, cmdReg[7:0]})
      else $error("banked operand address wrong");
   chk_read_wait: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
      else $error("read answer not in second cycle");
   chk_busy_stall: assert property (fileRdEn |-> (!write || waitrequest) [*3])
      else $error("write taken while busy");
   // main scenarios
   cover property (fileWrEn && cmdReg[10]);
   cover property (write && waitrequest);
   cover property (instrDone && !cmdReg[8]);
   cover property (read && !waitrequest && address == `RID_OFS_STATUS);
endmodule // rid_chk
`default_nettype wire

/* bench/rid_file_mem.sv */
// model of the data memory behind the file register port.
// assumes reads are answered combinationally while the strobe is high.
`timescale 1ns/1ns
`default_nettype none
module rid_file_mem
(
   // clock and file port
   input wire logic        clock,
   input wire logic [11:0] fileAddr,
   input wire logic        fileRdEn,
   output logic [7:0]      fileRdData,
   input wire logic        fileWrEn,
   input wire logic [7:0]  fileWrData
);
   logic [7:0] mem [0:4095]; // preloaded by the bench
   logic [7:0] lastVal;      // last value handed out
   // outside a read the bus shows the inverse so a stale sample shows up
   assign fileRdData = fileRdEn ? mem[fileAddr] : ~lastVal;
   // write in phase four, remember read data
   always @(posedge clock)
   begin
      if (fileRdEn) lastVal <= mem[fileAddr];
      if (fileWrEn) mem[fileAddr] <= fileWrData;
   end
   initial lastVal = 8'h00;
endmodule // rid_file_mem
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for the rotate datapath over its register bus.
// assumes rid_top, the file memory model and the checker are compiled.
`timescale 1ns/1ns
`default_nettype none
`include "rid_consts.vh"
module tb_top;
   logic        clock, nrst, read, write, waitrequest, fileRdEn, fileWrEn, instrDone;
   logic [7:0]  address, fileRdData, fileWrData;
   logic [3:0]  byteenable;
   logic [31:0] writedata, readdata, rdVal;
   logic [11:0] fileAddr;
   int          n_fail, num_checks;
   rid_top dut (.clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .fileAddr(fileAddr), .fileRdEn(fileRdEn),
      .fileRdData(fileRdData), .fileWrEn(fileWrEn), .fileWrData(fileWrData),
      .instrDone(instrDone));
   rid_file_mem fm (.clock(clock), .fileAddr(fileAddr), .fileRdEn(fileRdEn),
      .fileRdData(fileRdData), .fileWrEn(fileWrEn), .fileWrData(fileWrData));
   always #2 clock = ~clock;
   // ******************************************************************
   // helpers
   // ******************************************************************
   function automatic logic [7:0] pat(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], a[11:8]};
   endfunction
   // expected left rotate of one byte: msb wraps into lsb
   function automatic logic [7:0] rol(input logic [7:0] x);
      return {x[6:0], x[7]};
   endfunction
   task automatic give_verdict;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one bus cycle; waitrequest and data are sampled settled before the edge
   task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] dat,
      input logic [3:0] be);
      logic w;
      int   i;
      @(posedge clock);
      address <= adr;
      writedata <= dat;
      byteenable <= be;
      read <= !wr;
      write <= wr;
      for (i = 0; i < 40; i++)
      begin
         @(negedge clock);
         w = waitrequest;
         rdVal = readdata;
         @(posedge clock);
         if (w === 1'b0) break;
      end
      read <= 1'b0;
      write <= 1'b0;
      if (i == 40)
      begin
         n_fail++;
         give_verdict();
      end
   endtask
   // launch one rotate and wait for its completion pulse
   task automatic run_op(input logic op, acc, dest, input logic [7:0] f);
      int i;
      bus(1'b1, `RID_OFS_CMD, {21'h0, op, acc, dest, f}, 4'hF);
      // look only after the accept edge settles: a pulse of an earlier
      // instruction may still stand in the accept cycle itself
      for (i = 0; i < 20; i++)
      begin
         @(negedge clock);
         if (instrDone === 1'b1) break;
      end
      if (i == 20)
      begin
         n_fail++;
         give_verdict();
      end
   endtask
   // ******************************************************************
   // scenarios
   // ******************************************************************
   task automatic s_reset;
      bus(1'b0, `RID_OFS_CMD, 0, 4'hF);
      check("cmd reset", 32'h300, rdVal);
      bus(1'b0, `RID_OFS_STATUS, 0, 4'hF);
      check("status reset", 32'h0, rdVal);
      bus(1'b1, `RID_OFS_WORK, 32'h5A, 4'h0);
      bus(1'b0, `RID_OFS_WORK, 0, 4'hF);
      check("work no lanes", 32'h0, rdVal);
      bus(1'b0, 8'h20, 0, 4'hF);
      check("unmapped", 32'h0, rdVal);
   endtask
   task automatic s_rotl_file;
      logic [7:0] v;
      v = pat(12'h381);
      bus(1'b1, `RID_OFS_BANK, 32'h3, 4'hF);
      run_op(1'b0, 1'b1, 1'b1, 8'h81);
      check("rotl mem", {v[6:0], v[7]}, fm.mem[12'h381]);
      bus(1'b0, `RID_OFS_STATUS, 0, 4'hF);
      check("rotl flags", {v[6], 2'b00}, rdVal[2:0]);
   endtask
   task automatic s_rotr_work;
      logic [7:0] v;
      v = pat(12'hF70);
      bus(1'b1, `RID_OFS_STATUS, 32'h1, 4'hF);
      run_op(1'b1, 1'b0, 1'b0, 8'h70);
      bus(1'b0, `RID_OFS_WORK, 0, 4'hF);
      check("rotr work", {1'b1, v[7:1]}, rdVal);
      check("rotr src kept", v, fm.mem[12'hF70]);
      bus(1'b0, `RID_OFS_STATUS, 0, 4'hF);
      check("rotr flags", {2'b10, v[0]}, rdVal[2:0]);
   endtask
   task automatic s_indexed;
      bus(1'b1, `RID_OFS_CTRL, 32'h1, 4'hF);
      bus(1'b1, `RID_OFS_INDEX, 32'h200, 4'hF);
      run_op(1'b0, 1'b0, 1'b1, 8'h5F);
      check("index edge", rol(pat(12'h25F)), fm.mem[12'h25F]);
      run_op(1'b0, 1'b0, 1'b1, 8'h60);
      check("above index", rol(pat(12'hF60)), fm.mem[12'hF60]);
      bus(1'b1, `RID_OFS_CTRL, 32'h0, 4'hF);
      run_op(1'b0, 1'b0, 1'b1, 8'h10);
      check("ext off", rol(pat(12'h010)), fm.mem[12'h010]);
   endtask
   task automatic s_back;
      fm.mem[12'h011] = 8'h00;
      fm.mem[12'h012] = 8'h01;
      bus(1'b1, `RID_OFS_STATUS, 32'h0, 4'hF);
      bus(1'b1, `RID_OFS_CMD, 32'h511, 4'hF);
      run_op(1'b1, 1'b0, 1'b1, 8'h12);
      check("first zero", 32'h0, fm.mem[12'h011]);
      check("lsb out", 32'h0, fm.mem[12'h012]);
      bus(1'b0, `RID_OFS_STATUS, 0, 4'hF);
      check("zero carry", 3'b011, rdVal[2:0]);
   endtask
   // reset in mid instruction: no write back, command and status registers back to reset values
   task automatic s_midreset;
      bus(1'b1, `RID_OFS_CMD, 32'h113, 4'hF);
      @(posedge clock);
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      bus(1'b0, `RID_OFS_CMD, 0, 4'hF);
      check("cmd after reset", 32'h300, rdVal);
      check("no write back", pat(12'h013), fm.mem[12'h013]);
      bus(1'b0, `RID_OFS_STATUS, 0, 4'hF);
      check("status after reset", 32'h0, rdVal);
   endtask
   initial
   begin
      clock = 1'b0;
      nrst = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 8'h00;
      byteenable = 4'h0;
      writedata = 32'h0;
      n_fail = 0;
      num_checks = 0;
      for (int i = 0; i < 4096; i++)
         fm.mem[i] = pat(i[11:0]);
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      s_reset();
      s_rotl_file();
      s_rotr_work();
      s_indexed();
      s_back();
      s_midreset();
      give_verdict();
   end
endmodule // tb_top
bind rid_top rid_chk chk (.clock(clock), .nrst(nrst), .address(address), .read(read),
   .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .fileAddr(fileAddr), .fileRdEn(fileRdEn),
   .fileRdData(fileRdData), .fileWrEn(fileWrEn), .fileWrData(fileWrData),
   .instrDone(instrDone));
`default_nettype wire
